/* asq_pkg.sv */
// Shared constants for the conversion sequencer link and its two ends.
package asq_pkg;
  // Clock rate and the documented times, with their cycle counts.
  localparam int CLK_MHZ = 100;
  localparam int T_NS_CONVERSION_START_PIN_MIN = 40;
  localparam int T_NS_ACQ_MIN = 1400;
  localparam int T_NS_SAMPLE = 500;
  localparam int T_US_REF_SU = 45;
  localparam int CYC_CONVERSION_START_PIN_MIN = (T_NS_CONVERSION_START_PIN_MIN * CLK_MHZ + 999) / 1000;
  localparam int CYC_ACQ_MIN = (T_NS_ACQ_MIN * CLK_MHZ + 999) / 1000;
  localparam int CYC_SAMPLE = (T_NS_SAMPLE * CLK_MHZ) / 1000;
  localparam int CYC_REF_SU = T_US_REF_SU * CLK_MHZ;
  // Result format and code weights.
  localparam int ADC_BITS = 10;
  localparam int ADC_STEPS = 1024;
  localparam int TEMP_BITS = 12;
  localparam int TEMP_STEP_MILLI_C = 125;
  localparam int LEAD_ZEROS = 4;
  localparam int SUB_BITS = 2;
  localparam int FIFO_DEPTH = 17;
  // Command byte layout.
  localparam int OP_LSB = 6;
  localparam logic [1:0] OP_NOP = 2'h0;
  localparam logic [1:0] OP_SETUP = 2'h1;
  localparam logic [1:0] OP_CONV = 2'h2;
  localparam logic [1:0] OP_EXT = 2'h3;
  localparam int SET_CKM_LSB = 4;
  localparam int SET_AVG_LSB = 2;
  localparam int SET_TMP_BIT = 1;
  localparam int SET_BIP_BIT = 0;
  localparam int CONV_LAST_LSB = 0;
  // Clock modes.
  localparam logic [1:0] CKM_INT_CNV = 2'h0;
  localparam logic [1:0] CKM_EXT_ACQ = 2'h1;
  localparam logic [1:0] CKM_INT_CMD = 2'h2;
  localparam logic [1:0] CKM_RESET = CKM_INT_CMD;
  // Host register map and fields.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_CNVLOW = 8'h0C;
  localparam int CMD_OP_BIT = 8;
  localparam int CMD_AWAIT_BIT = 9;
  localparam int CMD_NB_LSB = 10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EOC_BIT = 1;
  localparam int STAT_PEND_BIT = 2;
  localparam int SCLK_HALF_CYC = 8;
  localparam int NB_DEFAULT = 8;
endpackage

/* asq_link_if.sv */
// Serial link and conversion pins between the host and the converter.
`timescale 1ns/1ps
interface asq_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic conversion_start_pin_n;
  logic eoc_n;
  modport dev (input cs_n, input sclk, input mosi, input conversion_start_pin_n,
    output miso, output eoc_n);
  modport host (output cs_n, output sclk, output mosi, output conversion_start_pin_n,
    input miso, input eoc_n);
endinterface

/* asq_dev.sv */
// Converter end: scan sequencer, result FIFO and serial read-out.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// (RULE1) Word: four zeros, ten bits, two subbits.
// (RULE2) Data output changes on serial clock falls.
// (RULE3) Unipolar binary; bipolar and temperature two's complement.
// (RULE4) Step is reference over 1024, 0.125 C.
// (RULE5) Partial first byte skips to second byte.
// (RULE6) Partial second byte discarded, others stay.
// (RULE7) Write shorter than eight clocks is ignored.
// (RULE8) Host waits for end flag before select.
// (RULE9) Mode 00: start pulse runs full scan.
// (RULE10) End flag low until select or start.
// (RULE11) Temperature result leads the scan results.
// (RULE12) Mode 00: no start pulse before end.
// (RULE13) Host reads only after all conversions.
// (RULE14) Extension writes accepted during conversions.
// (RULE15) Mode 01: start low starts tracking.
// (RULE16) Mode 01 temperature: device times reference.
// (RULE17) Mode 01: start rise converts, flag low.
// (RULE18) Mode 01: host waits for end flag.
// (RULE19) Mode 01: pulse count matches programmed conversions.
// (RULE20) Averaging stores one result, next channel.
// (RULE21) Mode 01 temperature on first start rise.
// (RULE22) Reset mode 10; command byte runs scan.
// (RULE23) Entry removed after both bytes done.
module asq_dev #(
  parameter int DEPTH = asq_pkg::FIFO_DEPTH, // FIFO entries.
  parameter int REF_SU_CYC = asq_pkg::CYC_REF_SU // Reference start-up cycles.
) (
  input wire logic core_clk, // System clock.
  input wire logic reset_n, // Synchronous reset.
  asq_link_if.dev link, // Link pins.
  output logic conv_req, // Start one conversion, pulse.
  output logic [2:0] conv_ch, // Channel to convert.
  output logic conv_tmp, // Conversion is temperature.
  output logic conv_bip, // Bipolar differential input.
  input wire logic conv_done, // Conversion finished, pulse.
  input wire logic [9:0] conv_code, // Raw offset-binary code.
  input wire logic [11:0] temp_code, // Temperature, two's complement.
  output logic ext_wr_valid, // Extension register write, pulse.
  output logic [7:0] ext_wr_byte // Extension write byte.
);
  if (DEPTH < 2 || DEPTH > 31) begin
    $error("asq_dev: DEPTH out of range");
  end
  if (REF_SU_CYC < 1 || REF_SU_CYC > 65535) begin
    $error("asq_dev: REF_SU_CYC out of range");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WAKE = 4'b0010,
    S_SAMPLE = 4'b0100,
    S_CONV = 4'b1000
  } asq_dstate_t;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] sclk_s;
    logic [1:0] mosi_s;
    logic [2:0] cnv_s;
    logic [1:0] ckm;
    logic [1:0] avg;
    logic tmp_en;
    logic bip;
    logic [2:0] last_ch;
    logic [2:0] ch;
    logic armed;
    logic tmp_pend;
    logic [7:0] sh;
    logic [2:0] bcnt;
    logic bsel;
    logic miso;
    logic eoc_n;
    asq_dstate_t st;
    logic [15:0] cnt;
    logic [2:0] nav;
    logic [12:0] acc;
    logic [DEPTH-1:0][15:0] mem;
    logic [4:0] wp;
    logic [4:0] rp;
    logic [5:0] cntf;
    logic conv_req;
    logic ext_vld;
    logic [7:0] ext_byte;
  } asq_dst_t;

  asq_dst_t r;
  asq_dst_t n;

  function automatic logic [4:0] ptr_inc(input logic [4:0] p);
    return (p == 5'(DEPTH - 1)) ? 5'h00 : p + 5'h01;
  endfunction

  // Averaged code to output word; bipolar flips the sign bit of offset binary.
  function automatic logic [15:0] pack_res(input logic [12:0] sum, input logic [1:0] sh,
      input logic bip);
    logic [9:0] c;
    c = 10'(sum >> sh);
    c[9] = c[9] ^ bip; // RULE3
    return {4'h0, c, 2'b00}; // RULE1 RULE4
  endfunction

  always_comb begin
    logic rise;
    logic fall;
    logic cs_low;
    logic cs_fall;
    logic cs_rise;
    logic cnv_rise;
    logic cnv_fall;
    logic byte_done;
    logic adv;
    logic pop;
    logic push;
    logic [7:0] cmd;
    logic [15:0] word;
    logic [15:0] pw;
    logic [12:0] sum;
    rise = r.sclk_s[1] & ~r.sclk_s[2];
    fall = ~r.sclk_s[1] & r.sclk_s[2];
    cs_low = ~r.cs_s[1];
    cs_fall = ~r.cs_s[1] & r.cs_s[2];
    cs_rise = r.cs_s[1] & ~r.cs_s[2];
    cnv_rise = r.cnv_s[1] & ~r.cnv_s[2];
    cnv_fall = ~r.cnv_s[1] & r.cnv_s[2];
    byte_done = 1'b0;
    adv = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    pw = 16'h0000;
    cmd = {r.sh[6:0], r.mosi_s[1]};
    word = (r.cntf != 6'h00) ? r.mem[r.rp] : 16'h0000;
    sum = r.acc + 13'(conv_code);
    n = r;
    n.conv_req = 1'b0;
    n.ext_vld = 1'b0;
    n.cs_s = {r.cs_s[1:0], link.cs_n};
    n.sclk_s = {r.sclk_s[1:0], link.sclk};
    n.mosi_s = {r.mosi_s[0], link.mosi};
    n.cnv_s = {r.cnv_s[1:0], link.conversion_start_pin_n};

    // Serial side: bit position within the head entry and command shift.
    if (cs_fall) begin
      n.eoc_n = 1'b1; // RULE10
      n.miso = word[4'(~{r.bsel, r.bcnt})];
    end
    if (cnv_fall && r.ckm != asq_pkg::CKM_INT_CMD) begin
      n.eoc_n = 1'b1; // RULE10
    end
    if (cs_low && rise) begin
      n.sh = cmd;
      n.bcnt = r.bcnt + 3'h1;
      byte_done = (r.bcnt == 3'h7);
      adv = byte_done;
    end
    if (cs_low && fall) begin
      n.miso = word[4'(~{r.bsel, r.bcnt})]; // RULE2
    end
    // A byte cut short is dropped: its bits are skipped and its command is lost.
    if (cs_rise && r.bcnt != 3'h0) begin
      n.bcnt = 3'h0; // RULE7
      adv = 1'b1; // RULE5 RULE6
    end
    if (adv) begin
      n.bsel = ~r.bsel;
      pop = r.bsel && (r.cntf != 6'h00); // RULE23
    end

    // Sequencer.
    case (r.st)
      S_IDLE: begin
        if (r.armed && cnv_rise &&
            (r.ckm == asq_pkg::CKM_INT_CNV || r.ckm == asq_pkg::CKM_EXT_ACQ)) begin
          n.st = S_WAKE; // RULE9 RULE17 RULE21
          n.cnt = 16'h0000;
        end
      end
      S_WAKE: begin
        if (!r.tmp_pend || r.cnt == 16'(REF_SU_CYC - 1)) begin
          n.st = S_SAMPLE; // RULE16
          n.cnt = 16'h0000;
        end else begin
          n.cnt = r.cnt + 16'h0001;
        end
      end
      S_SAMPLE: begin
        if (r.cnt == 16'(asq_pkg::CYC_SAMPLE - 1)) begin
          n.st = S_CONV; // RULE17
          n.conv_req = 1'b1;
        end else begin
          n.cnt = r.cnt + 16'h0001;
        end
      end
      S_CONV: begin
        if (conv_done) begin
          n.cnt = 16'h0000;
          n.st = S_SAMPLE;
          if (r.tmp_pend) begin
            push = 1'b1; // RULE11
            pw = {4'h0, temp_code}; // RULE3
            n.tmp_pend = 1'b0;
          end else if (r.nav == 3'((1 << r.avg) - 1)) begin
            push = 1'b1; // RULE20
            pw = pack_res(sum, r.avg, r.bip);
            n.acc = 13'h0000;
            n.nav = 3'h0;
            n.ch = r.ch + 3'h1;
            if (r.ch == r.last_ch) begin
              n.armed = 1'b0;
              n.st = S_IDLE;
              n.eoc_n = 1'b0; // RULE10
            end
          end else begin
            n.acc = sum;
            n.nav = r.nav + 3'h1;
          end
          // Externally paced mode converts once per start pulse.
          if (r.ckm == asq_pkg::CKM_EXT_ACQ) begin
            n.st = S_IDLE; // RULE17 RULE19
            n.eoc_n = 1'b0; // RULE10
          end
        end
      end
      default: n.st = S_IDLE;
    endcase

    // FIFO update; a full FIFO drops the new result.
    if (push && (r.cntf - 6'(pop)) < 6'(DEPTH)) begin
      n.mem[r.wp] = pw;
      n.wp = ptr_inc(r.wp);
    end else begin
      push = 1'b0;
    end
    if (pop) begin
      n.rp = ptr_inc(r.rp);
    end
    n.cntf = r.cntf + 6'(push) - 6'(pop);

    // Command execution at the eighth clock of a full byte.
    if (byte_done) begin
      case (cmd[7:6])
        asq_pkg::OP_SETUP: begin
          n.ckm = cmd[asq_pkg::SET_CKM_LSB +: 2];
          n.avg = cmd[asq_pkg::SET_AVG_LSB +: 2];
          n.tmp_en = cmd[asq_pkg::SET_TMP_BIT];
          n.bip = cmd[asq_pkg::SET_BIP_BIT];
        end
        asq_pkg::OP_CONV: begin
          n.last_ch = cmd[asq_pkg::CONV_LAST_LSB +: 3];
          n.ch = 3'h0;
          n.armed = 1'b1;
          n.tmp_pend = r.tmp_en;
          n.nav = 3'h0;
          n.acc = 13'h0000;
          n.wp = 5'h00;
          n.rp = 5'h00;
          n.cntf = 6'h00;
          n.bsel = 1'b0;
          n.st = S_IDLE;
          if (r.ckm == asq_pkg::CKM_INT_CMD) begin
            n.st = S_WAKE; // RULE22
            n.cnt = 16'h0000;
          end
        end
        asq_pkg::OP_EXT: begin
          n.ext_vld = 1'b1; // RULE14
          n.ext_byte = cmd;
        end
        default: n.ext_vld = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r <= '0;
      r.cs_s <= 3'h7;
      r.cnv_s <= 3'h7;
      r.ckm <= asq_pkg::CKM_RESET; // RULE22
      r.eoc_n <= 1'b1;
      r.st <= S_IDLE;
    end else begin
      r <= n;
    end
  end

  assign link.miso = r.miso;
  assign link.eoc_n = r.eoc_n;
  assign conv_req = r.conv_req;
  assign conv_ch = r.ch;
  assign conv_tmp = r.tmp_pend;
  assign conv_bip = r.bip;
  assign ext_wr_valid = r.ext_vld;
  assign ext_wr_byte = r.ext_byte;
endmodule

/* asq_host.sv */
// Host end: APB-controlled serial master and conversion-start driver.
`timescale 1ns/1ps
module asq_host #(
  parameter int HALF = asq_pkg::SCLK_HALF_CYC // Core cycles per serial clock half.
) (
  input wire logic core_clk, // System clock.
  input wire logic reset_n, // Synchronous reset.
  input wire logic [7:0] paddr, // APB address.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  asq_link_if.host link // Link pins.
);
  // Below eight cycles the device's synchronisers cannot turn data round in time.
  if (HALF < 8 || HALF > 255) begin
    $error("asq_host: HALF out of range");
  end

  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_WAIT = 6'b000010,
    H_LOW = 6'b000100,
    H_HIGH = 6'b001000,
    H_GUARD = 6'b010000,
    H_CNV = 6'b100000
  } asq_hstate_t;

  typedef struct packed {
    asq_hstate_t st;
    logic [15:0] cnt;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic cnv_n;
    logic [1:0] miso_s;
    logic [1:0] eoc_s;
    logic op_cnv;
    logic await;
    logic [7:0] tx;
    logic [4:0] nbit;
    logic [15:0] rx;
    logic [15:0] rdata;
    logic [15:0] cnvlow;
    logic pend;
    logic [31:0] prdata;
  } asq_hst_t;

  asq_hst_t r;
  asq_hst_t n;

  function automatic logic hit(input logic [7:0] a);
    return a == asq_pkg::REG_CMD || a == asq_pkg::REG_STAT ||
      a == asq_pkg::REG_RDATA || a == asq_pkg::REG_CNVLOW;
  endfunction

  always_comb begin
    logic acc_wr;
    logic [4:0] nb;
    acc_wr = psel && penable && pwrite;
    nb = pwdata[asq_pkg::CMD_NB_LSB +: 5];
    n = r;
    n.miso_s = {r.miso_s[0], link.miso};
    n.eoc_s = {r.eoc_s[0], link.eoc_n};
    n.cnt = r.cnt + 16'h0001;

    // Read data is registered in the setup cycle and stands through the access.
    if (psel && !penable) begin
      case (paddr)
        asq_pkg::REG_STAT: n.prdata = 32'({r.pend, ~r.eoc_s[1], r.st != H_IDLE});
        asq_pkg::REG_RDATA: n.prdata = 32'(r.rdata);
        asq_pkg::REG_CNVLOW: n.prdata = 32'(r.cnvlow);
        default: n.prdata = 32'h0000_0000;
      endcase
    end
    if (acc_wr && paddr == asq_pkg::REG_CNVLOW) begin
      n.cnvlow = (pwdata[15:0] < 16'(asq_pkg::CYC_CONVERSION_START_PIN_MIN)) ?
        16'(asq_pkg::CYC_CONVERSION_START_PIN_MIN) : pwdata[15:0]; // RULE9 RULE15 RULE16
    end

    case (r.st)
      H_IDLE: begin
        if (acc_wr && paddr == asq_pkg::REG_CMD) begin
          n.tx = pwdata[7:0];
          n.op_cnv = pwdata[asq_pkg::CMD_OP_BIT];
          n.await = pwdata[asq_pkg::CMD_AWAIT_BIT];
          n.nbit = (nb == 5'h00 || nb > 5'h10) ? 5'(asq_pkg::NB_DEFAULT) : nb;
          n.st = H_WAIT;
        end
      end
      H_WAIT: begin
        // While pend is set by a start pulse or an awaited transfer, neither select nor start moves until the end flag reports the last scan.
        if (!r.pend || !r.eoc_s[1]) begin
          n.pend = 1'b0; // RULE8 RULE12 RULE13 RULE18
          n.cnt = 16'h0000;
          if (r.op_cnv) begin
            n.cnv_n = 1'b0; // RULE19
            n.st = H_CNV;
          end else begin
            n.cs_n = 1'b0;
            n.mosi = r.tx[7];
            n.tx = {r.tx[6:0], 1'b0};
            n.rx = 16'h0000;
            n.st = H_LOW;
          end
        end
      end
      H_CNV: begin
        if (r.cnt == r.cnvlow - 16'h0001) begin
          n.cnv_n = 1'b1;
          n.pend = 1'b1;
          n.cnt = 16'h0000;
          n.st = H_GUARD;
        end
      end
      H_LOW: begin
        if (r.cnt == 16'(HALF - 1)) begin
          n.sclk = 1'b1;
          n.rx = {r.rx[14:0], r.miso_s[1]};
          n.nbit = r.nbit - 5'h01;
          n.cnt = 16'h0000;
          n.st = H_HIGH;
        end
      end
      H_HIGH: begin
        if (r.cnt == 16'(HALF - 1)) begin
          n.cnt = 16'h0000;
          if (r.nbit == 5'h00) begin
            // The serial clock falls as the select rises, so the next frame opens on a clean rise.
            n.sclk = 1'b0;
            n.cs_n = 1'b1;
            n.rdata = r.rx;
            n.pend = r.await;
            n.st = H_GUARD;
          end else begin
            n.sclk = 1'b0;
            n.mosi = r.tx[7];
            n.tx = {r.tx[6:0], 1'b0};
            n.st = H_LOW;
          end
        end
      end
      H_GUARD: begin
        // Lets the end flag's rise reach this side before it is trusted again.
        if (r.cnt == 16'(HALF - 1)) begin
          n.st = H_IDLE;
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r <= '0;
      r.st <= H_IDLE;
      r.cs_n <= 1'b1;
      r.cnv_n <= 1'b1;
      r.eoc_s <= 2'h3;
      r.cnvlow <= 16'(asq_pkg::CYC_CONVERSION_START_PIN_MIN);
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit(paddr);
  assign link.sclk = r.sclk;
  assign link.cs_n = r.cs_n;
  assign link.mosi = r.mosi;
  assign link.conversion_start_pin_n = r.cnv_n;
endmodule

/* asq_props.sv */
// Checker for the serial link between the host end and the converter end.
`timescale 1ns/1ps
module asq_props (
  input wire logic core_clk, // System clock.
  input wire logic reset_n, // Synchronous reset.
  input wire logic cs_n, // Select.
  input wire logic sclk, // Serial clock.
  input wire logic mosi, // Host data.
  input wire logic miso, // Device data.
  input wire logic conversion_start_pin_n, // Start.
  input wire logic eoc_n // End flag.
);
  logic cnv_q_r;
  logic pend_r;
  // A start rise leaves work outstanding until the end flag is seen low.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnv_q_r <= 1'b1;
      pend_r <= 1'b0;
    end else begin
      cnv_q_r <= conversion_start_pin_n;
      if (conversion_start_pin_n && !cnv_q_r) begin
        pend_r <= 1'b1;
      end else if (!eoc_n) begin
        pend_r <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_high_phase;
    sclk [*7] ##1 !sclk;
  endsequence
  sequence s_sel_edge;
    $fell(cs_n) || $rose(cs_n);
  endsequence
  AST_SCLK_HALF: assert property ($rose(sclk) |=> s_high_phase)
    else $error("serial clock high phase has the wrong length");
  AST_MOSI_HOLD: assert property ($rose(sclk) |=> $stable(mosi) [*7])
    else $error("host data moved while serial clock high");
  AST_MISO_HOLD: assert property ($rose(sclk) && !cs_n |=> $stable(miso) [*7])
    else $error("device data moved while serial clock high");
  AST_CS_EDGE: assert property (s_sel_edge |-> !sclk)
    else $error("select moved while serial clock high");
  AST_EOC_HOLD: assert property (!eoc_n && cs_n && conversion_start_pin_n |=> !eoc_n)
    else $error("end flag released without select or start");
  AST_EOC_CAUSE: assert property ($rose(eoc_n) |-> !cs_n || !conversion_start_pin_n)
    else $error("end flag rose with select and start idle");
  AST_SEL_WAIT: assert property ($fell(cs_n) |-> !pend_r)
    else $error("select fell before end of conversion");
  AST_START_WAIT: assert property ($fell(conversion_start_pin_n) |-> !pend_r)
    else $error("start fell before end of conversion");
  AST_SAMPLE: assert property ($rose(conversion_start_pin_n) && eoc_n |=> eoc_n [*8])
    else $error("end flag came before sampling could finish");
  AST_START_LOW: assert property ($fell(conversion_start_pin_n) |=> !conversion_start_pin_n [*3])
    else $error("start pulse too short");
endmodule

/* testbench.sv */
// Self-checking bench for both ends of the conversion link.
`timescale 1ns/1ps
module testbench;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, ext_wr_byte, ext_last;
  logic [31:0] pwdata, prdata, rd;
  logic conv_req, conv_tmp, conv_bip, conv_done, ext_wr_valid, jit, tgl;
  logic [2:0] conv_ch;
  logic [9:0] conv_code;
  logic [11:0] temp_code;
  int n_mismatch, n_compared, n_ext, n_tmp;
  asq_link_if link ();
  asq_host #(.HALF(8)) u_asq_host (.core_clk, .reset_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .link(link));
  asq_dev #(.DEPTH(17), .REF_SU_CYC(20)) u_asq_dev (.core_clk, .reset_n, .link(link),
    .conv_req, .conv_ch, .conv_tmp, .conv_bip, .conv_done, .conv_code, .temp_code,
    .ext_wr_valid, .ext_wr_byte);
  asq_props u_asq_props (.core_clk, .reset_n, .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .miso(link.miso), .eoc_n(link.eoc_n),
    .conversion_start_pin_n(link.conversion_start_pin_n));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Converter stand-in: answers each request one cycle later.
  always @(posedge core_clk) begin
    conv_done <= conv_req;
    if (conv_req) begin
      conv_code <= 10'h100 + 10'(conv_ch) * 10'h021 + ((jit && tgl) ? 10'h002 : 10'h000);
      tgl <= ~tgl;
    end
    if (conv_req && conv_tmp) begin
      n_tmp <= n_tmp + 1;
    end
    if (ext_wr_valid) begin
      n_ext <= n_ext + 1;
      ext_last <= ext_wr_byte;
    end
  end
  function automatic logic [31:0] wd(input logic [9:0] c);
    return {20'h0, c, 2'b00};
  endfunction
  function automatic logic [9:0] bs(input logic [2:0] ch);
    return 10'h100 + 10'(ch) * 10'h021;
  endfunction
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sop(input logic [7:0] b, input logic [4:0] nb, input logic st);
    apb(1'b1, asq_pkg::REG_CMD, {17'h0, nb, 1'b0, st, b});
    do begin
      apb(1'b0, asq_pkg::REG_STAT, 32'h0);
    end while (rd[asq_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic w_eoc();
    do begin
      apb(1'b0, asq_pkg::REG_STAT, 32'h0);
    end while (rd[asq_pkg::STAT_EOC_BIT] !== 1'b1);
  endtask
  // Reads nb bits through a no-op byte stream; only the bits shifted in are compared.
  task automatic rde(input logic [4:0] nb, input logic [31:0] exp);
    logic [31:0] m;
    m = (32'h1 << nb) - 32'h1;
    sop(8'h00, nb, 1'b0);
    apb(1'b0, asq_pkg::REG_RDATA, 32'h0);
    chk(exp & m, rd & m);
  endtask
  task automatic t_scan10();
    sop(8'h82, 5'd8, 1'b0);
    w_eoc();
    rde(5'd4, 32'h0);
    rde(5'd8, wd(bs(3'd0)));
    rde(5'd16, wd(bs(3'd1)));
    rde(5'd8, wd(bs(3'd2)) >> 8);
    rde(5'd3, wd(bs(3'd2)) >> 5);
    rde(5'd16, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'h1, {31'h0, er});
  endtask
  task automatic t_tmp();
    sop(8'h63, 5'd8, 1'b0);
    sop(8'h80, 5'd8, 1'b0);
    w_eoc();
    chk(32'h1, 32'(n_tmp));
    chk(32'h1, {31'h0, conv_bip});
    rde(5'd16, {20'h0, 12'hF38});
    rde(5'd16, wd(bs(3'd0) ^ 10'h200));
  endtask
  task automatic t_avg();
    jit = 1'b1;
    sop(8'h64, 5'd8, 1'b0);
    sop(8'h81, 5'd8, 1'b0);
    w_eoc();
    rde(5'd16, wd(bs(3'd0) + 10'h001));
    rde(5'd16, wd(bs(3'd1) + 10'h001));
    jit = 1'b0;
  endtask
  task automatic t_m00();
    sop(8'h40, 5'd8, 1'b0);
    sop(8'h81, 5'd8, 1'b0);
    chk(32'h0, {31'h0, rd[asq_pkg::STAT_EOC_BIT]});
    sop(8'h00, 5'd8, 1'b1);
    w_eoc();
    rde(5'd16, wd(bs(3'd0)));
    rde(5'd16, wd(bs(3'd1)));
  endtask
  task automatic t_m01();
    int e;
    apb(1'b1, asq_pkg::REG_CNVLOW, 32'h2);
    apb(1'b0, asq_pkg::REG_CNVLOW, 32'h0);
    chk(32'h4, rd);
    apb(1'b1, asq_pkg::REG_CNVLOW, 32'(asq_pkg::CYC_ACQ_MIN));
    sop(8'h50, 5'd8, 1'b0);
    sop(8'h81, 5'd8, 1'b0);
    // Extension bytes go in while the scan is armed and the FIFO is still empty.
    // Every byte also steps the read position, so they must not land between results.
    e = n_ext;
    sop(8'hC5, 5'd5, 1'b0);
    chk(32'(e), 32'(n_ext));
    sop(8'hC5, 5'd8, 1'b0);
    chk(32'(e + 1), 32'(n_ext));
    chk(32'hC5, {24'h0, ext_last});
    sop(8'h00, 5'd8, 1'b1);
    sop(8'h00, 5'd8, 1'b1);
    w_eoc();
    rde(5'd16, wd(bs(3'd0)));
    rde(5'd16, wd(bs(3'd1)));
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {reset_n, psel, penable, pwrite, conv_done, jit, tgl} = 7'h0;
    {paddr, pwdata, conv_code} = 50'h0;
    temp_code = 12'hF38;
    n_mismatch = 0;
    n_compared = 0;
    n_ext = 0;
    n_tmp = 0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_scan10();
    t_tmp();
    t_avg();
    t_m00();
    t_m01();
    wrap_up();
  end
  // The whole sequence needs well under a tenth of this span.
  initial begin
    #900000;
    n_mismatch++;
    wrap_up();
  end
endmodule
